/* hdl/trigger_model_defines.svh */
`ifndef TRIGGER_MODEL_DEFINES_SVH
`define TRIGGER_MODEL_DEFINES_SVH

// counts
`define COUNT_W          12
`define COUNT_MAX        12'h0_BB8
`define COUNT_ONE        12'h0_001
`define COUNT_ZERO       12'h0_000
// time base: 100 MHz core clock, 0.1 ms delay tick, 1 ms timer tick
`define CLK_HZ           100000000
`define DELAY_TICK_US    100
`define TIMER_TICK_US    1000
`define DELAY_W          24
`define DELAY_MAX        24'h98_967F
`define TIMER_W          27
`define TIMER_MAX        27'h5F5_E0FF
`define PRE_W            17
`define PRE_ZERO         17'h0_0000
`define PRE_ONE          17'h0_0001
// event source codes
`define SRC_W            3
`define SRC_IMM          3'h0
`define SRC_LINK         3'h1
`define SRC_TIMER        3'h2
`define SRC_MANUAL       3'h3
`define SRC_BUS          3'h4
`define SRC_SOT_LOW      3'h5
`define SRC_SOT_HIGH     3'h6
`define SRC_SOT_EITHER   3'h7

`endif

/* hdl/trigger_model_pkg.sv */
`include "trigger_model_defines.svh"

package trigger_model_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE      = 3'b000,
        ST_ARM_WAIT  = 3'b001,
        ST_TRIG_WAIT = 3'b010,
        ST_DELAY     = 3'b011,
        ST_ACTION    = 3'b100
    } seq_state_type;

    typedef struct packed
    {
        logic                  armInfinite;
        logic [`COUNT_W-1:0]   armCount;
        logic [`COUNT_W-1:0]   trigCount;
        logic [`SRC_W-1:0]     armSource;
        logic [`SRC_W-1:0]     trigSource;
        logic [`DELAY_W-1:0]   trigDelay;
        logic [`TIMER_W-1:0]   timerInterval;
    } seq_config_type;

    typedef struct packed
    {
        logic initiate;
        logic readQuery;
        logic measureQuery;
        logic abort;
        logic deviceClear;
        logic interfaceClear;
        logic presetReset;
        logic busTrigger;
        logic otherCommand;
        logic haltEvent;
        logic fetchQuery;
        logic limitResultQuery;
    } seq_cmd_type;

endpackage

/* hdl/trigger_model_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trigger_model_defines.svh"

// How it works
// - initiate leaves idle, runs arm/trigger layers
// - read or measure query also initiates
// - stall commands while running, except listed ones
// - after stray command, only clears still act
// - abort returns to idle immediately
// - inner loop runs fully per outer pass
// - counts 1 to 3000, default one
// - reject settings whose product exceeds 3000
// - infinite only on outer; queries refused
// - delay 0 to 999.9999 seconds
// - wait delay after each trigger event
// - eight selectable event sources on the outer layer
// - inner layer takes only immediate or link
// - link source waits for link pulse
// - timer fires at once, then each interval
// - manual source waits for front key
// - bus source waits for bus trigger
// - low start-of-test pulse is event
// - high start-of-test pulse is event
// - either polarity start-of-test is event
// - timer interval 1 ms to 99999.999 s
module trigger_model_sequencer
(
    input  wire logic                           core_clk,
    input  wire logic                           resetn,
    input  wire trigger_model_pkg::seq_config_type cfgIn,
    input  wire logic                           cfgLoad,
    input  wire trigger_model_pkg::seq_cmd_type cmdIn,
    input  wire logic                           link_trigger_pulse,
    input  wire logic                           front_panel_trigger_key,
    input  wire logic                           start_of_test_pulse,
    output logic                                cfgReject,
    output logic                                cmdStall,
    output logic                                cmdAccept,
    output logic                                queryRefused,
    output logic                                running,
    output logic                                actionStrobe,
    output logic [`COUNT_W-1:0]                 armPassCount,
    output logic [`COUNT_W-1:0]                 trigPassCount
);

    localparam int DELAY_TICK_CYC = `CLK_HZ / 1000000 * `DELAY_TICK_US;
    localparam int TIMER_TICK_CYC = `CLK_HZ / 1000000 * `TIMER_TICK_US;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sotSync_q;
    logic [2:0] linkSync_q;
    logic [2:0] keySync_q;
    logic       sotLevel_q;
    logic       linkLevel_q;
    logic       keyLevel_q;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sotSync_q   <= 3'h7;
            linkSync_q  <= 3'h0;
            keySync_q   <= 3'h0;
            sotLevel_q  <= 1'b1;
            linkLevel_q <= 1'b0;
            keyLevel_q  <= 1'b0;
        end
        else
        begin
            sotSync_q  <= {sotSync_q[1:0], start_of_test_pulse};
            linkSync_q <= {linkSync_q[1:0], link_trigger_pulse};
            keySync_q  <= {keySync_q[1:0], front_panel_trigger_key};
            if (sotSync_q[1] == sotSync_q[2])
                sotLevel_q <= sotSync_q[2];
            if (linkSync_q[1] == linkSync_q[2])
                linkLevel_q <= linkSync_q[2];
            if (keySync_q[1] == keySync_q[2])
                keyLevel_q <= keySync_q[2];
        end
    end

    wire sotAgree  = sotSync_q[1] == sotSync_q[2];
    wire linkAgree = linkSync_q[1] == linkSync_q[2];
    wire keyAgree  = keySync_q[1] == keySync_q[2];
    wire sotFall   = sotAgree && sotLevel_q && !sotSync_q[2];
    wire sotRise   = sotAgree && !sotLevel_q && sotSync_q[2];
    wire linkRise  = linkAgree && !linkLevel_q && linkSync_q[2];
    wire keyRise   = keyAgree && !keyLevel_q && keySync_q[2];

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    trigger_model_pkg::seq_config_type cfg_q;
    trigger_model_pkg::seq_state_type  state_q;
    trigger_model_pkg::seq_state_type  state_d;

    wire [23:0] countProduct = cfgIn.armCount * cfgIn.trigCount;
    wire countLowBad  = cfgIn.trigCount == `COUNT_ZERO
                        || (!cfgIn.armInfinite && cfgIn.armCount == `COUNT_ZERO);
    wire countHighBad = cfgIn.trigCount > `COUNT_MAX
                        || (!cfgIn.armInfinite && countProduct > {12'h000, `COUNT_MAX});
    wire srcBad       = cfgIn.trigSource != `SRC_IMM && cfgIn.trigSource != `SRC_LINK;
    wire rangeBad     = cfgIn.trigDelay > `DELAY_MAX
                        || cfgIn.timerInterval > `TIMER_MAX
                        || cfgIn.timerInterval == {`TIMER_W{1'b0}};
    wire idle         = state_q == trigger_model_pkg::ST_IDLE;
    wire cfgBad       = countLowBad || countHighBad || srcBad || rangeBad;
    wire cfgTake      = cfgLoad && idle && !cfgBad;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_q <= '{armInfinite: 1'b0, armCount: `COUNT_ONE, trigCount: `COUNT_ONE,
                       armSource: `SRC_IMM, trigSource: `SRC_IMM,
                       trigDelay: '0, timerInterval: 27'h000_0001};
        end
        else if (cfgTake)
            cfg_q <= cfgIn;
    end

    // ------------------------------------------------------------
    // command gating
    // ------------------------------------------------------------
    logic strayCmd_q;
    wire clearCmd   = cmdIn.deviceClear || cmdIn.interfaceClear;
    wire stopCmd    = cmdIn.abort || cmdIn.presetReset || cmdIn.haltEvent;
    wire abortNow   = clearCmd || (!strayCmd_q && stopCmd);
    wire busSource  = cfg_q.armSource == `SRC_BUS;
    wire busTrigOk  = !strayCmd_q && busSource && cmdIn.busTrigger;
    wire queryInit  = (cmdIn.readQuery || cmdIn.measureQuery) && !cfg_q.armInfinite;
    wire startReq   = idle && (cmdIn.initiate || queryInit);
    wire strayNow   = !idle && (cmdIn.otherCommand || cmdIn.initiate
                                || cmdIn.readQuery || cmdIn.measureQuery
                                || cmdIn.fetchQuery || cmdIn.limitResultQuery
                                || (cmdIn.busTrigger && !busTrigOk));

    assign cmdStall     = strayNow;
    assign cmdAccept    = startReq || abortNow || busTrigOk || (idle && cmdIn.otherCommand);
    assign queryRefused = cfg_q.armInfinite && (cmdIn.readQuery || cmdIn.measureQuery
                          || cmdIn.fetchQuery || cmdIn.limitResultQuery);
    assign running      = !idle;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            strayCmd_q <= 1'b0;
        else if (idle || abortNow)
            strayCmd_q <= 1'b0;
        else if (strayNow)
            strayCmd_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // interval timer and delay
    // ------------------------------------------------------------
    logic [`PRE_W-1:0]   timerPre_q;
    logic [`TIMER_W-1:0] timerCnt_q;
    logic                timerFired_q;
    logic [`PRE_W-1:0]   delayPre_q;
    logic [`DELAY_W-1:0] delayCnt_q;

    wire timerTick = timerPre_q == `PRE_W'(TIMER_TICK_CYC - 1);
    wire timerWrap = timerTick && timerCnt_q == cfg_q.timerInterval - `TIMER_W'(1);
    wire delayTick = delayPre_q == `PRE_W'(DELAY_TICK_CYC - 1);
    wire delayDone = delayCnt_q == cfg_q.trigDelay;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            timerPre_q   <= `PRE_ZERO;
            timerCnt_q   <= '0;
            timerFired_q <= 1'b0;
        end
        else if (idle || abortNow)
        begin
            timerPre_q   <= `PRE_ZERO;
            timerCnt_q   <= '0;
            timerFired_q <= 1'b1;
        end
        else
        begin
            timerPre_q <= timerTick ? `PRE_ZERO : timerPre_q + `PRE_ONE;
            if (timerWrap)
                timerCnt_q <= '0;
            else if (timerTick)
                timerCnt_q <= timerCnt_q + `TIMER_W'(1);
            if (timerWrap)
                timerFired_q <= 1'b1;
            else if (state_q == trigger_model_pkg::ST_ARM_WAIT
                     && cfg_q.armSource == `SRC_TIMER)
                timerFired_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            delayPre_q <= `PRE_ZERO;
            delayCnt_q <= '0;
        end
        else if (state_q != trigger_model_pkg::ST_DELAY || abortNow)
        begin
            delayPre_q <= `PRE_ZERO;
            delayCnt_q <= '0;
        end
        else
        begin
            delayPre_q <= delayTick ? `PRE_ZERO : delayPre_q + `PRE_ONE;
            if (delayTick)
                delayCnt_q <= delayCnt_q + `DELAY_W'(1);
        end
    end

    // ------------------------------------------------------------
    // event source selection
    // ------------------------------------------------------------
    // every event travels as an argument so the callers see each change
    wire [7:0] srcHits = {sotFall || sotRise, sotRise, sotFall, busTrigOk,
                          keyRise, timerFired_q, linkRise, 1'b1};

    function automatic logic srcEvent(input logic [`SRC_W-1:0] src, input logic [7:0] hits);
        unique case (src)
            `SRC_IMM:        srcEvent = hits[`SRC_IMM];
            `SRC_LINK:       srcEvent = hits[`SRC_LINK];
            `SRC_TIMER:      srcEvent = hits[`SRC_TIMER];
            `SRC_MANUAL:     srcEvent = hits[`SRC_MANUAL];
            `SRC_BUS:        srcEvent = hits[`SRC_BUS];
            `SRC_SOT_LOW:    srcEvent = hits[`SRC_SOT_LOW];
            `SRC_SOT_HIGH:   srcEvent = hits[`SRC_SOT_HIGH];
            `SRC_SOT_EITHER: srcEvent = hits[`SRC_SOT_EITHER];
        endcase
    endfunction

    wire armEvent  = srcEvent(cfg_q.armSource, srcHits);
    wire trigEvent = srcEvent(cfg_q.trigSource, srcHits);

    // ------------------------------------------------------------
    // layer sequencing
    // ------------------------------------------------------------
    wire lastTrig = trigPassCount == cfg_q.trigCount - `COUNT_ONE;
    wire lastArm  = !cfg_q.armInfinite && armPassCount == cfg_q.armCount - `COUNT_ONE;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            trigger_model_pkg::ST_IDLE:
                if (startReq)
                    state_d = trigger_model_pkg::ST_ARM_WAIT;
            trigger_model_pkg::ST_ARM_WAIT:
                if (armEvent)
                    state_d = trigger_model_pkg::ST_TRIG_WAIT;
            trigger_model_pkg::ST_TRIG_WAIT:
                if (trigEvent)
                    state_d = trigger_model_pkg::ST_DELAY;
            trigger_model_pkg::ST_DELAY:
                if (delayDone)
                    state_d = trigger_model_pkg::ST_ACTION;
            trigger_model_pkg::ST_ACTION:
                if (!lastTrig)
                    state_d = trigger_model_pkg::ST_TRIG_WAIT;
                else if (!lastArm)
                    state_d = trigger_model_pkg::ST_ARM_WAIT;
                else
                    state_d = trigger_model_pkg::ST_IDLE;
            default:
                state_d = trigger_model_pkg::ST_IDLE;
        endcase
        if (abortNow)
            state_d = trigger_model_pkg::ST_IDLE;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q       <= trigger_model_pkg::ST_IDLE;
            armPassCount  <= `COUNT_ZERO;
            trigPassCount <= `COUNT_ZERO;
            actionStrobe  <= 1'b0;
            cfgReject     <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            actionStrobe <= state_q == trigger_model_pkg::ST_ACTION && !abortNow;
            cfgReject    <= cfgLoad && (cfgBad || !idle);
            if (idle || abortNow)
            begin
                armPassCount  <= `COUNT_ZERO;
                trigPassCount <= `COUNT_ZERO;
            end
            else if (state_q == trigger_model_pkg::ST_ACTION)
            begin
                trigPassCount <= lastTrig ? `COUNT_ZERO : trigPassCount + `COUNT_ONE;
                if (lastTrig && !cfg_q.armInfinite)
                    armPassCount <= armPassCount + `COUNT_ONE;
            end
        end
    end

endmodule

`default_nettype wire

/* bench/handler_model.sv */
`timescale 1ns/1ps
`default_nettype none

// far side: link source, front key and component handler pins
module handler_model
(
    input  wire logic core_clk,
    output var logic link_trigger_pulse,
    output var logic front_panel_trigger_key,
    output var logic start_of_test_pulse
);
    initial
    begin
        link_trigger_pulse = 1'b0;
        front_panel_trigger_key = 1'b0;
        start_of_test_pulse = 1'b1;
    end

    // kind 0 link, 1 key, 2 start-of-test low pulse whose end is the rise
    task automatic fire(input int kind);
        @(posedge core_clk);
        case (kind)
            0: link_trigger_pulse <= 1'b1;
            1: front_panel_trigger_key <= 1'b1;
            default: start_of_test_pulse <= 1'b0;
        endcase
        repeat (4) @(posedge core_clk);
        link_trigger_pulse <= 1'b0;
        front_panel_trigger_key <= 1'b0;
        start_of_test_pulse <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* bench/trigger_model_sequencer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trigger_model_defines.svh"

module seq_checker
(
    input wire logic                              core_clk,
    input wire logic                              resetn,
    input wire trigger_model_pkg::seq_config_type cfgIn,
    input wire logic                              cfgLoad,
    input wire trigger_model_pkg::seq_cmd_type    cmdIn,
    input wire logic                              cfgReject,
    input wire logic                              cmdStall,
    input wire logic                              cmdAccept,
    input wire logic                              queryRefused,
    input wire logic                              running,
    input wire logic                              actionStrobe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_start;
        !running && cmdIn.initiate;
    endsequence
    sequence s_load;
        cfgLoad && !cfgIn.armInfinite;
    endsequence

    a_init_runs: assert property (s_start |=> running)
        else $error("initiate left sequencer idle");
    a_read_runs: assert property (!running && cmdIn.readQuery && !queryRefused |=> running)
        else $error("read query left sequencer idle");
    a_start_cause: assert property ($rose(running) |-> $past(cmdAccept))
        else $error("run began without a taken command");
    a_stall_other: assert property (running && cmdIn.otherCommand |-> cmdStall)
        else $error("command not stalled while running");
    a_idle_nostall: assert property (!running |-> !cmdStall)
        else $error("stall while idle");
    a_clear_idle: assert property (cmdIn.deviceClear |=> !running)
        else $error("device clear did not stop run");
    a_abort_idle: assert property (cmdIn.abort && cmdAccept |=> !running)
        else $error("abort did not stop run");
    a_strobe_single: assert property (actionStrobe |=> !actionStrobe)
        else $error("action strobe longer than one cycle");
    a_count_reject: assert property (cfgLoad && (cfgIn.trigCount == 0 ||
        cfgIn.trigCount > `COUNT_MAX) |=> cfgReject)
        else $error("bad trigger count accepted");
    a_prod_reject: assert property (s_load ##0 (32'(cfgIn.armCount) * 32'(cfgIn.trigCount)
        > 32'(`COUNT_MAX)) |=> cfgReject)
        else $error("count product above limit accepted");
    a_src_reject: assert property (cfgLoad && cfgIn.trigSource > `SRC_LINK |=> cfgReject)
        else $error("inner layer source accepted");
    a_busy_reject: assert property (cfgLoad && running |=> cfgReject)
        else $error("config taken while running");
endmodule

bind trigger_model_sequencer seq_checker chk (.core_clk, .resetn, .cfgIn, .cfgLoad, .cmdIn,
    .cfgReject, .cmdStall, .cmdAccept, .queryRefused, .running, .actionStrobe);
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trigger_model_defines.svh"

module tb_top;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    trigger_model_pkg::seq_config_type cfgIn;
    trigger_model_pkg::seq_cmd_type cmdIn, c;
    logic cfgLoad, link_trigger_pulse, front_panel_trigger_key, start_of_test_pulse;
    logic cfgReject, cmdStall, cmdAccept, queryRefused, running, actionStrobe;
    logic [`COUNT_W-1:0] armPassCount, trigPassCount;
    logic [31:0] lfsr = 32'h0000_029f;
    logic [2:0] asrc [7] = '{`SRC_LINK, `SRC_MANUAL, `SRC_BUS, `SRC_SOT_LOW,
        `SRC_SOT_HIGH, `SRC_SOT_EITHER, `SRC_IMM};
    int knd [7] = '{0, 1, 3, 2, 2, 2, 0};
    int ba [6] = '{2, 2, 1, 1, 3000, 1};
    int bt [6] = '{1500, 1501, 3001, 0, 1, 1};
    int err_count = 0;
    int checks = 0;
    int n, a, t;
    logic stallSeen, refSeen, accSeen;

    always #5 core_clk = ~core_clk;

    trigger_model_sequencer uut (.core_clk, .resetn, .cfgIn, .cfgLoad, .cmdIn,
        .link_trigger_pulse, .front_panel_trigger_key, .start_of_test_pulse, .cfgReject,
        .cmdStall, .cmdAccept, .queryRefused, .running, .actionStrobe, .armPassCount,
        .trigPassCount);
    handler_model hnd (.core_clk, .link_trigger_pulse, .front_panel_trigger_key,
        .start_of_test_pulse);

    function automatic logic [31:0] next_rand(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic trigger_model_pkg::seq_config_type mk(int a, int t, logic [2:0] as,
        logic [2:0] ts, int d, logic inf);
        mk = '0;
        mk.armInfinite = inf;
        mk.armCount = a[11:0];
        mk.trigCount = t[11:0];
        mk.armSource = as;
        mk.trigSource = ts;
        mk.trigDelay = d[23:0];
        mk.timerInterval = 27'h000_0001;
    endfunction

    function automatic logic exp_rej(int a, int t, logic [2:0] ts);
        return a < 1 || t < 1 || t > `COUNT_MAX || a * t > `COUNT_MAX || ts > `SRC_LINK;
    endfunction

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic load(trigger_model_pkg::seq_config_type v, logic rej);
        @(posedge core_clk);
        cfgIn <= v;
        cfgLoad <= 1'b1;
        @(posedge core_clk);
        cfgLoad <= 1'b0;
        #1 check("cfgReject", 32'(cfgReject), 32'(rej));
    endtask

    task automatic cmd(trigger_model_pkg::seq_cmd_type v);
        @(posedge core_clk);
        cmdIn <= v;
        #1 stallSeen = cmdStall;
        refSeen = queryRefused;
        accSeen = cmdAccept;
        @(posedge core_clk);
        cmdIn <= '0;
    endtask

    task automatic go(int f);
        c = '0;
        c[11 - f] = 1'b1;
        cmd(c);
    endtask

    // counts action strobes until the run ends
    task automatic run_to_idle(int expn, int bound, int tc);
        int i;
        n = 0;
        for (i = 0; i < bound; i++)
        begin
            @(posedge core_clk);
            #1 if (actionStrobe === 1'b1)
            begin
                n++;
                check("trigPass", 32'(trigPassCount), 32'(n % tc));
                check("armPass", 32'(armPassCount), 32'(n / tc));
            end
            if (running === 1'b0) break;
        end
        if (i == bound)
        begin
            check("idle_wait", 32'h0000_0001, 32'h0000_0000);
            print_verdict();
        end
        else
            check("actions", 32'(n), 32'(expn));
    endtask

    initial
    begin
        cfgIn = mk(1, 1, `SRC_IMM, `SRC_IMM, 0, 1'b0);
        cfgLoad = 1'b0;
        cmdIn = '0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        #1 check("running", 32'(running), 32'h0000_0000);
        go(0);
        run_to_idle(1, 20, 1);
        for (int k = 1; k < 3; k++)
        begin
            go(k);
            run_to_idle(1, 20, 1);
        end
        $display("test defaults done");
        for (int i = 0; i < 6; i++)
            load(mk(ba[i], bt[i], `SRC_IMM, i == 5 ? `SRC_TIMER : `SRC_IMM, 0, 1'b0),
                exp_rej(ba[i], bt[i], i == 5 ? `SRC_TIMER : `SRC_IMM));
        repeat (8)
        begin
            lfsr = next_rand(lfsr);
            load(mk(int'(lfsr[11:0]), int'(lfsr[23:12]), `SRC_IMM, lfsr[26:24], 0, 1'b0),
                exp_rej(int'(lfsr[11:0]), int'(lfsr[23:12]), lfsr[26:24]));
        end
        repeat (4)
        begin
            lfsr = next_rand(lfsr);
            a = 1 + int'(lfsr[1:0]);
            t = 1 + int'(lfsr[4:2]);
            load(mk(a, t, `SRC_IMM, `SRC_IMM, 0, 1'b0), 1'b0);
            go(0);
            run_to_idle(a * t, 400, t);
        end
        $display("test counts done");
        for (int i = 0; i < 7; i++)
        begin
            load(mk(1, 1, asrc[i], i == 6 ? `SRC_LINK : `SRC_IMM, 0, 1'b0), 1'b0);
            go(0);
            repeat (8) @(posedge core_clk);
            #1 check("held", 32'(running), 32'h0000_0001);
            if (knd[i] == 3)
            begin
                go(7);
                check("bus_stall", 32'(stallSeen), 32'h0000_0000);
                check("bus_accept", 32'(accSeen), 32'h0000_0001);
            end
            else
                hnd.fire(knd[i]);
            run_to_idle(1, 40, 1);
        end
        load(mk(1, 1, `SRC_TIMER, `SRC_IMM, 0, 1'b0), 1'b0);
        go(0);
        run_to_idle(1, 20, 1);
        $display("test sources done");
        load(mk(1, 1, `SRC_IMM, `SRC_IMM, 1, 1'b0), 1'b0);
        go(0);
        repeat (9990) @(posedge core_clk);
        #1 check("delay_wait", 32'(running), 32'h0000_0001);
        run_to_idle(1, 40, 1);
        $display("test delay done");
        load(mk(1, 1, `SRC_IMM, `SRC_IMM, 0, 1'b1), 1'b0);
        go(0);
        load(mk(1, 1, `SRC_IMM, `SRC_IMM, 0, 1'b0), 1'b1);
        go(7);
        check("bus_other", 32'(stallSeen), 32'h0000_0001);
        go(8);
        check("stall", 32'(stallSeen), 32'h0000_0001);
        go(1);
        check("refused", 32'(refSeen), 32'h0000_0001);
        go(3);
        #1 check("abort_late", 32'(running), 32'h0000_0001);
        check("abort_taken", 32'(accSeen), 32'h0000_0000);
        go(4);
        #1 check("clear", 32'(running), 32'h0000_0000);
        go(0);
        go(3);
        #1 check("abort", 32'(running), 32'h0000_0000);
        load(mk(2, 2, `SRC_IMM, `SRC_IMM, 0, 1'b0), 1'b0);
        go(0);
        go(3);
        #1 check("abort_mid", 32'(running), 32'h0000_0000);
        go(0);
        run_to_idle(4, 100, 2);
        $display("test abort done");
        print_verdict();
    end
endmodule
`default_nettype wire
